// ---- verilog/oam_regs_pkg.sv ----
// Constants shared by the partner message and link restart register bank.
package oam_regs_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MMD_W = 5;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned REG_ADDR_W = 12;
  localparam int unsigned MSG_W = 64;
  localparam int unsigned MSG_WORDS = 4;
  localparam int unsigned MSG_NUM_W = 4;
  localparam int unsigned SNR_W = 2;

  // ==========================================================================
  // Register spaces and printed offsets
  localparam logic [MMD_W-1:0] MMD_PMA_SPACE = 5'h03;
  localparam logic [MMD_W-1:0] MMD_AN_SPACE = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_RX_STATUS = 16'h3909;
  localparam logic [ADDR_W-1:0] OFS_RX_WORD_0 = 16'h390A;
  localparam logic [ADDR_W-1:0] OFS_RX_WORD_1 = 16'h390B;
  localparam logic [ADDR_W-1:0] OFS_RX_WORD_2 = 16'h390C;
  localparam logic [ADDR_W-1:0] OFS_RX_WORD_3 = 16'h390D;
  localparam logic [ADDR_W-1:0] OFS_LINK_RESTART = 16'h7200;

  // ==========================================================================
  // Field positions
  localparam int unsigned STAT_READY_BIT = 15;
  localparam int unsigned STAT_TOGGLE_BIT = 14;
  localparam int unsigned STAT_NUM_LSB = 8;
  localparam int unsigned STAT_SNR_LSB = 0;
  localparam int unsigned RESTART_BIT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [MSG_W-1:0] RST_MSG = 64'h0000_0000_0000_0000;
  localparam logic [MSG_NUM_W-1:0] RST_NUM = 4'h0;
  localparam logic [SNR_W-1:0] RST_SNR = 2'h0;

endpackage

// ---- verilog/oam_regs_if.sv ----
// Interface between the register front end and its two storage modules.
`timescale 1ns/1ps
`default_nettype none

interface oam_regs_if;
  import oam_regs_pkg::*;

  // Stored partner message and its status.
  logic [MSG_W-1:0] message;
  logic [MSG_NUM_W-1:0] number;
  logic toggle;
  logic [SNR_W-1:0] snr;
  logic ready;
  logic clear_on_read;

  // Link restart control.
  logic restart_wr;
  logic restart_wbit;
  logic restart_bit;

  modport capture (
    output message,
    output number,
    output toggle,
    output snr,
    output ready,
    input clear_on_read
  );

  modport restart (
    input restart_wr,
    input restart_wbit,
    output restart_bit
  );

  modport regs (
    input message,
    input number,
    input toggle,
    input snr,
    input ready,
    output clear_on_read,
    output restart_wr,
    output restart_wbit,
    input restart_bit
  );
endinterface

`default_nettype wire

// ---- verilog/oam_msg_capture.sv ----
// Holds the first unread partner message as one snapshot with its ready flag.
`timescale 1ns/1ps
`default_nettype none

module oam_msg_capture (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Received frame from the receive path
  input wire logic frame_stb,
  input wire logic [oam_regs_pkg::MSG_W-1:0] frame_msg,
  input wire logic [oam_regs_pkg::MSG_NUM_W-1:0] frame_num,
  input wire logic frame_toggle,
  input wire logic [oam_regs_pkg::SNR_W-1:0] frame_snr,
  // Register side
  oam_regs_if.capture view
);
  import oam_regs_pkg::*;

  logic load;
  logic ready_r;
  logic [MSG_W-1:0] message_r;
  logic [MSG_NUM_W-1:0] number_r;
  logic toggle_r;
  logic [SNR_W-1:0] snr_r;

  // ==========================================================================
  // Load decision
  // A held message is not overwritten until software has read the last
  // word, so a slow reader never sees octets of two messages. A frame
  // landing in the clearing cycle is still taken.
  assign load = frame_stb && (!ready_r || view.clear_on_read);

  // ==========================================================================
  // Snapshot storage
  // RULE_11: one frame, one load.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      message_r <= RST_MSG;
      number_r <= RST_NUM;
      toggle_r <= 1'b0;
      snr_r <= RST_SNR;
    end else if (load) begin
      message_r <= frame_msg;
      number_r <= frame_num;
      toggle_r <= frame_toggle;
      snr_r <= frame_snr;
    end
  end

  // ==========================================================================
  // Ready flag
  // RULE_10: set on stored message.
  // RULE_09: cleared on last-word read.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ready_r <= 1'b0;
    end else if (load) begin
      ready_r <= 1'b1;
    end else if (view.clear_on_read) begin
      ready_r <= 1'b0;
    end
  end

  assign view.message = message_r;
  assign view.number = number_r;
  assign view.toggle = toggle_r;
  assign view.snr = snr_r;
  assign view.ready = ready_r;

endmodule

`default_nettype wire

// ---- verilog/link_restart_ctrl.sv ----
// Self-clearing link synchronisation restart bit.
`timescale 1ns/1ps
`default_nettype none

module link_restart_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register side
  oam_regs_if.restart ctl
);
  import oam_regs_pkg::*;

  logic restart_bit_r;

  // ==========================================================================
  // Restart bit
  // RULE_07: write one, self clear.
  // RULE_08: zero after reset.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      restart_bit_r <= 1'b0;
    end else begin
      restart_bit_r <= ctl.restart_wr && ctl.restart_wbit;
    end
  end

  assign ctl.restart_bit = restart_bit_r;

endmodule

`default_nettype wire

// ---- verilog/oam_rx_message_and_link_reset_regs.sv ----
// Register bank for the received partner message and the link restart bit.
//
// Overview of operation
// RULE_01: Word zero shows message octets one, zero.
// RULE_02: Word one shows message octets three, two.
// RULE_03: Word two shows message octets five, four.
// RULE_04: Word three shows message octets seven, six.
// RULE_05: Space three; top nibble ignored in address.
// RULE_06: Restart word in space seven, nibble ignored.
// RULE_07: Writing one restarts link, bit self clears.
// RULE_08: Restart word resets zero; upper bits zero.
// RULE_09: Reading word three clears message ready flag.
// RULE_10: Ready flag bit fifteen set on stored message.
// RULE_11: All words and flag load from one frame.
`timescale 1ns/1ps
`default_nettype none

module oam_rx_message_and_link_reset_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register access port
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [oam_regs_pkg::MMD_W-1:0] reg_mmd,
  input wire logic [oam_regs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [oam_regs_pkg::DATA_W-1:0] reg_wdata,
  output logic [oam_regs_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_ack,
  // Received frames from the receive path
  input wire logic frame_stb,
  input wire logic [oam_regs_pkg::MSG_W-1:0] frame_msg,
  input wire logic [oam_regs_pkg::MSG_NUM_W-1:0] frame_num,
  input wire logic frame_toggle,
  input wire logic [oam_regs_pkg::SNR_W-1:0] frame_snr,
  // Link control and status
  output logic link_sync_restart,
  output logic partner_msg_ready
);
  import oam_regs_pkg::*;

  oam_regs_if bank ();

  logic in_pma;
  logic in_an;
  logic [REG_ADDR_W-1:0] local_addr;
  logic hit_status;
  logic hit_restart;
  logic [MSG_WORDS-1:0] hit_word;
  logic [DATA_W-1:0] partner_msg_octets_1_0;
  logic [DATA_W-1:0] partner_msg_octets_3_2;
  logic [DATA_W-1:0] partner_msg_octets_5_4;
  logic [DATA_W-1:0] partner_msg_octets_7_6;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] restart_word;
  logic [DATA_W-1:0] reg_rdata_nxt;
  logic [DATA_W-1:0] reg_rdata_r;
  logic reg_ack_r;
  logic link_sync_restart_r;
  logic partner_msg_ready_r;

  // ==========================================================================
  // Storage modules
  oam_msg_capture u_capture (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .frame_stb(frame_stb),
    .frame_msg(frame_msg),
    .frame_num(frame_num),
    .frame_toggle(frame_toggle),
    .frame_snr(frame_snr),
    .view(bank.capture)
  );

  link_restart_ctrl u_restart (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ctl(bank.restart)
  );

  // ==========================================================================
  // Address decode
  // The top nibble of the printed offset only repeats the register space,
  // so it is not compared; a caller may present it or leave it zero.
  // RULE_05: space three, low twelve bits.
  // RULE_06: space seven, low twelve bits.
  assign local_addr = reg_addr[REG_ADDR_W-1:0];
  assign in_pma = (reg_mmd == MMD_PMA_SPACE);
  assign in_an = (reg_mmd == MMD_AN_SPACE);
  assign hit_status = in_pma &&
    (local_addr == OFS_RX_STATUS[REG_ADDR_W-1:0]);
  // The four message words sit at consecutive offsets in space three.
  for (genvar w = 0; w < MSG_WORDS; w++) begin : g_word_hit
    assign hit_word[w] = in_pma && (local_addr ==
      OFS_RX_WORD_0[REG_ADDR_W-1:0] + REG_ADDR_W'(w));
  end
  assign hit_restart = in_an &&
    (local_addr == OFS_LINK_RESTART[REG_ADDR_W-1:0]);

  // ==========================================================================
  // Message words
  // The first bit on the line lands in the least significant bit.
  // RULE_01: octets one and zero.
  assign partner_msg_octets_1_0 = bank.message[DATA_W-1:0];
  // RULE_02: octets three and two.
  assign partner_msg_octets_3_2 = bank.message[2*DATA_W-1:DATA_W];
  // RULE_03: octets five and four.
  assign partner_msg_octets_5_4 = bank.message[3*DATA_W-1:2*DATA_W];
  // RULE_04: octets seven and six.
  assign partner_msg_octets_7_6 = bank.message[4*DATA_W-1:3*DATA_W];

  // ==========================================================================
  // Status and restart words
  // RULE_10: ready flag in bit fifteen.
  always_comb begin
    status_word = RST_WORD;
    status_word[STAT_READY_BIT] = bank.ready;
    status_word[STAT_TOGGLE_BIT] = bank.toggle;
    status_word[STAT_NUM_LSB +: MSG_NUM_W] = bank.number;
    status_word[STAT_SNR_LSB +: SNR_W] = bank.snr;
  end

  // RULE_08: upper bits read zero.
  always_comb begin
    restart_word = RST_WORD;
    restart_word[RESTART_BIT] = bank.restart_bit;
  end

  // ==========================================================================
  // Side effects of accesses
  // Writes to the read-only words are accepted and have no effect.
  // RULE_09: last-word read clears ready.
  assign bank.clear_on_read = reg_req && !reg_write && hit_word[3];
  // RULE_07: write strobe to restart bit.
  assign bank.restart_wr = reg_req && reg_write && hit_restart;
  assign bank.restart_wbit = reg_wdata[RESTART_BIT];

  // ==========================================================================
  // Read data mux
  // Unmapped addresses read as zero so software probing the space sees a
  // quiet answer rather than stale data.
  always_comb begin
    reg_rdata_nxt = RST_WORD;
    if (hit_status) begin
      reg_rdata_nxt = status_word;
    end else if (hit_word[0]) begin
      reg_rdata_nxt = partner_msg_octets_1_0;
    end else if (hit_word[1]) begin
      reg_rdata_nxt = partner_msg_octets_3_2;
    end else if (hit_word[2]) begin
      reg_rdata_nxt = partner_msg_octets_5_4;
    end else if (hit_word[3]) begin
      reg_rdata_nxt = partner_msg_octets_7_6;
    end else if (hit_restart) begin
      reg_rdata_nxt = restart_word;
    end
  end

  // ==========================================================================
  // Answer registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata_r <= RST_WORD;
    end else if (reg_req && !reg_write) begin
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_ack_r <= 1'b0;
    end else begin
      reg_ack_r <= reg_req;
    end
  end

  // ==========================================================================
  // Link outputs
  // The restart pulse is retimed here so it leaves the block from a local
  // flop; this costs one cycle against the internal bit.
  // RULE_07: restart pulse to link.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      link_sync_restart_r <= 1'b0;
    end else begin
      link_sync_restart_r <= bank.restart_bit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      partner_msg_ready_r <= 1'b0;
    end else begin
      partner_msg_ready_r <= bank.ready;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign reg_ack = reg_ack_r;
  assign link_sync_restart = link_sync_restart_r;
  assign partner_msg_ready = partner_msg_ready_r;

endmodule

`default_nettype wire

// ---- verif/oam_regs_assertions.sv ----
// Port checks for the partner message and link restart register bank.
`timescale 1ns/1ps
`default_nettype none

module oam_regs_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [4:0] reg_mmd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  // Frames and link status
  input wire logic frame_stb,
  input wire logic link_sync_restart,
  input wire logic partner_msg_ready
);
  import oam_regs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic rd3;
  logic wr_rst;
  logic rd_rst;
  assign rd3 = reg_req && !reg_write && reg_mmd == MMD_PMA_SPACE
    && reg_addr[11:0] == OFS_RX_WORD_3[11:0];
  assign rd_rst = reg_req && reg_mmd == MMD_AN_SPACE
    && reg_addr[11:0] == OFS_LINK_RESTART[11:0];
  assign wr_rst = rd_rst && reg_write && reg_wdata[0];

  // ==========================================================================
  // Port and flag relations
  AST_ACK: assert property (reg_req |=> reg_ack)
    else $error("request not acknowledged next cycle");
  AST_NOACK: assert property (!reg_req |=> !reg_ack)
    else $error("acknowledge without request");
  AST_RESTART: assert property (wr_rst |-> ##2 link_sync_restart)
    else $error("restart write gave no pulse");
  AST_RESTART_CAUSE: assert property (
    $rose(link_sync_restart) |-> $past(wr_rst, 2))
    else $error("restart pulse without a write");
  AST_PULSE: assert property (
    link_sync_restart && !$past(wr_rst) |=> !link_sync_restart)
    else $error("restart bit did not clear itself");
  AST_RSV_ZERO: assert property (
    rd_rst && !reg_write |=> reg_rdata[15:1] == 15'h0000)
    else $error("reserved restart bits read nonzero");
  AST_RDY_SET: assert property (frame_stb |-> ##2 partner_msg_ready)
    else $error("ready flag not set after frame");
  AST_RDY_CLR: assert property (
    rd3 && !frame_stb |-> ##2 !partner_msg_ready)
    else $error("ready flag not cleared by last word read");
  AST_RDY_HOLD: assert property (
    partner_msg_ready && !$past(rd3) |=> partner_msg_ready)
    else $error("ready flag dropped without read");
endmodule

bind oam_rx_message_and_link_reset_regs oam_regs_assertions chk (
  .clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req),
  .reg_write(reg_write), .reg_mmd(reg_mmd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .frame_stb(frame_stb), .link_sync_restart(link_sync_restart),
  .partner_msg_ready(partner_msg_ready));

`default_nettype wire

// ---- verif/oam_partner_model.sv ----
// Link partner model that offers received OAM frames to the bank.
`timescale 1ns/1ps
`default_nettype none

module oam_partner_model (
  // Clock
  input wire logic clk_sys,
  // Frame offer
  output logic frame_stb,
  output logic [63:0] frame_msg,
  output logic [3:0] frame_num,
  output logic frame_toggle,
  output logic [1:0] frame_snr
);
  initial begin
    frame_stb = 1'b0;
    frame_msg = 64'h0;
    frame_num = 4'h0;
    frame_toggle = 1'b0;
    frame_snr = 2'h0;
  end

  // After a frame the lines carry its inverse, so stale data cannot pass.
  task automatic send(input logic [63:0] m, input logic [3:0] n,
                      input logic t, input logic [1:0] s);
    @(posedge clk_sys);
    #1;
    frame_stb = 1'b1;
    frame_msg = m;
    frame_num = n;
    frame_toggle = t;
    frame_snr = s;
    @(posedge clk_sys);
    #1;
    frame_stb = 1'b0;
    frame_msg = ~m;
    frame_num = ~n;
    frame_toggle = ~t;
    frame_snr = ~s;
  endtask
endmodule

`default_nettype wire

// ---- verif/oam_rx_message_and_link_reset_regs_tb_top.sv ----
// Self-checking bench for the partner message and link restart registers.
`timescale 1ns/1ps
`default_nettype none

module oam_rx_message_and_link_reset_regs_tb_top;
  import oam_regs_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic reg_req = 1'b0;
  logic reg_write = 1'b0;
  logic [4:0] reg_mmd = 5'h00;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_ack;
  logic frame_stb;
  logic [63:0] frame_msg;
  logic [3:0] frame_num;
  logic frame_toggle;
  logic [1:0] frame_snr;
  logic link_sync_restart;
  logic partner_msg_ready;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  logic [15:0] rd;

  always #2 clk_sys = ~clk_sys;

  oam_rx_message_and_link_reset_regs dut (
    .clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req),
    .reg_write(reg_write), .reg_mmd(reg_mmd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .frame_stb(frame_stb), .frame_msg(frame_msg), .frame_num(frame_num),
    .frame_toggle(frame_toggle), .frame_snr(frame_snr),
    .link_sync_restart(link_sync_restart),
    .partner_msg_ready(partner_msg_ready));

  oam_partner_model partner (
    .clk_sys(clk_sys), .frame_stb(frame_stb), .frame_msg(frame_msg),
    .frame_num(frame_num), .frame_toggle(frame_toggle),
    .frame_snr(frame_snr));

  // ==========================================================================
  // Shared tasks
  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [4:0] mmd,
                     input logic [15:0] a, input logic [15:0] wd);
    @(posedge clk_sys);
    #1;
    reg_req = 1'b1;
    reg_write = wr;
    reg_mmd = mmd;
    reg_addr = a;
    reg_wdata = wd;
    @(posedge clk_sys);
    #1;
    reg_req = 1'b0;
    cmp({15'h0, reg_ack}, 16'h0001);
    rd = reg_rdata;
  endtask

  task automatic rd_chk(input logic [4:0] mmd, input logic [15:0] a,
                        input logic [15:0] exp);
    acc(1'b0, mmd, a, 16'h0000);
    cmp(rd, exp);
  endtask

  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset_values;
    for (int i = 0; i < 4; i++) begin
      rd_chk(5'h03, 16'h390A + 16'(i), 16'h0000);
    end
    rd_chk(5'h03, 16'h3909, 16'h0000);
    rd_chk(5'h07, 16'h7200, 16'h0000);
    $display("test reset_values done");
  endtask

  task automatic t_message;
    partner.send(64'h7766_5544_3322_1100, 4'h5, 1'b1, 2'h3);
    rd_chk(5'h03, 16'h3909, 16'hC503);
    rd_chk(5'h03, 16'h390A, 16'h1100);
    rd_chk(5'h03, 16'hF90B, 16'h3322);
    rd_chk(5'h03, 16'h090C, 16'h5544);
    acc(1'b1, 5'h03, 16'h390A, 16'hFFFF);
    rd_chk(5'h03, 16'h390A, 16'h1100);
    rd_chk(5'h01, 16'h390A, 16'h0000);
    cmp({15'h0, partner_msg_ready}, 16'h0001);
    rd_chk(5'h03, 16'h390D, 16'h7766);
    step();
    cmp({15'h0, partner_msg_ready}, 16'h0000);
    rd_chk(5'h03, 16'h3909, 16'h4503);
    $display("test message done");
  endtask

  task automatic t_snapshot;
    partner.send(64'h0123_4567_89AB_CDEF, 4'hA, 1'b0, 2'h2);
    partner.send(64'hFEDC_BA98_7654_3210, 4'h3, 1'b1, 2'h1);
    rd_chk(5'h03, 16'h390A, 16'hCDEF);
    rd_chk(5'h03, 16'h3909, 16'h8A02);
    rd_chk(5'h03, 16'h390D, 16'h0123);
    partner.send(64'hFEDC_BA98_7654_3210, 4'h3, 1'b1, 2'h1);
    rd_chk(5'h03, 16'h390C, 16'hBA98);
    rd_chk(5'h03, 16'h3909, 16'hC301);
    // A frame landing with the last-word read is kept and the flag stays.
    fork
      partner.send(64'h1111_2222_3333_4444, 4'h9, 1'b0, 2'h0);
      rd_chk(5'h03, 16'h390D, 16'hFEDC);
    join
    rd_chk(5'h03, 16'h3909, 16'h8900);
    rd_chk(5'h03, 16'h390A, 16'h4444);
    $display("test snapshot done");
  endtask

  task automatic t_restart;
    acc(1'b1, 5'h07, 16'h7200, 16'hFFFF);
    step();
    cmp({15'h0, link_sync_restart}, 16'h0001);
    step();
    cmp({15'h0, link_sync_restart}, 16'h0000);
    rd_chk(5'h07, 16'h7200, 16'h0000);
    acc(1'b1, 5'h07, 16'h0200, 16'h0001);
    step();
    cmp({15'h0, link_sync_restart}, 16'h0001);
    acc(1'b1, 5'h07, 16'h7200, 16'hFFFE);
    step();
    cmp({15'h0, link_sync_restart}, 16'h0000);
    acc(1'b1, 5'h03, 16'h7200, 16'h0001);
    step();
    cmp({15'h0, link_sync_restart}, 16'h0000);
    $display("test restart done");
  endtask

  // A reset in mid-run must drop a pending restart and the held message.
  task automatic t_mid_reset;
    acc(1'b1, 5'h07, 16'h7200, 16'h0001);
    resetn = 1'b0;
    step();
    cmp({15'h0, link_sync_restart}, 16'h0000);
    cmp({15'h0, partner_msg_ready}, 16'h0000);
    step();
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_chk(5'h03, 16'h390A + 16'(i), 16'h0000);
    end
    rd_chk(5'h03, 16'h3909, 16'h0000);
    rd_chk(5'h07, 16'h7200, 16'h0000);
    $display("test mid_reset done");
  endtask

  // ==========================================================================
  // Run control
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    t_reset_values();
    t_message();
    t_snapshot();
    t_restart();
    t_mid_reset();
    tally_and_finish();
  end
endmodule

`default_nettype wire
